//--- verif/adc_link_monitor.sv
// Checker on the link between the two converter ends.
`timescale 1ns/1ps
module adc_link_monitor (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Reset, active high.
   input wire logic conv_clk_i, // Conversion clock.
   input wire logic [adc_out_pkg::CODE_W-1:0] code_i, // Sample word.
   input wire logic out_of_range_flag_i // Range flag.
);
   import adc_out_pkg::*;
   logic conv_reg;
   logic conv_next;
   logic fall;
   assign conv_next = conv_clk_i;
   assign fall = conv_reg & ~conv_clk_i;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_reg <= 1'b0;
      end else begin
         conv_reg <= conv_next;
      end
   end
   // ****
   // Link properties
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_code_on_fall: assert property ($changed(code_i) |-> $past(fall))
      else $error("word moved off a fall");
   a_flag_on_fall: assert property ($changed(out_of_range_flag_i) |-> $past(fall))
      else $error("flag moved off a fall");
   a_flag_clamps: assert property (out_of_range_flag_i |-> code_i == CODE_MIN || code_i == CODE_MAX)
      else $error("flag high without clamped word");
   a_flag_holds: assert property (out_of_range_flag_i && !fall |=> out_of_range_flag_i)
      else $error("flag dropped between conversions");
   a_code_stands: assert property ($changed(code_i) |=> $stable(code_i)[*8] ##1 $stable(code_i)[*8])
      else $error("word changed twice in a period");
   a_pins_low_phase: assert property ($changed(code_i) |-> !conv_clk_i)
      else $error("word changed in high phase");
   a_clk_high_time: assert property ($rose(conv_clk_i) |-> conv_clk_i[*8] ##1 conv_clk_i ##1 !conv_clk_i)
      else $error("high time wrong");
   a_clk_low_time: assert property ($fell(conv_clk_i) |-> !conv_clk_i[*8] ##1 !conv_clk_i ##1 conv_clk_i)
      else $error("low time wrong");
endmodule : adc_link_monitor

//--- verif/test_adc_output_code_and_range_flag.sv
// Bench joining the converter output end to the capture end.
`timescale 1ns/1ps
module test_adc_output_code_and_range_flag;
   import adc_out_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic signed [ANALOG_W-1:0] analog_level_i = '0;
   logic sample_taken_o;
   logic sample_valid_o;
   logic [CODE_W-1:0] raw_code_o;
   logic [CODE_W-1:0] signed_code_o;
   range_class_e range_class_o;
   int num_errors = 0;
   int tests_run = 0;
   logic [31:0] seed = 32'h30923F4B;
   int corners[8] = '{-32768, -8193, -8192, -1, 0, 8191, 8192, 32767};
   adc_link_if link ();
   adc_sample_source i_adc_sample_source (.clk_i(clk_i), .rst_i(rst_i), .analog_level_i(analog_level_i),
      .sample_taken_o(sample_taken_o), .link(link));
   adc_sample_capture i_adc_sample_capture (.clk_i(clk_i), .rst_i(rst_i), .raw_code_o(raw_code_o),
      .signed_code_o(signed_code_o), .range_class_o(range_class_o), .sample_valid_o(sample_valid_o), .link(link));
   adc_link_monitor i_adc_link_monitor (.clk_i(clk_i), .rst_i(rst_i), .conv_clk_i(link.conv_clk),
      .code_i(link.code), .out_of_range_flag_i(link.out_of_range_flag));
   always #2.5 clk_i = ~clk_i;
   // ****
   // Helpers
   // ****
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   function automatic logic [CODE_W:0] expect_word(input int lvl);
      if (lvl < int'(LEVEL_NEG_REF)) return {1'b1, CODE_MIN};
      if (lvl >= int'(LEVEL_POS_REF)) return {1'b1, CODE_MAX};
      return {1'b0, CODE_W'(lvl - int'(LEVEL_NEG_REF))};
   endfunction : expect_word
   function automatic range_class_e expect_class(input logic [CODE_W:0] w);
      if (!w[CODE_W]) return CLASS_IN_RANGE;
      return w[CODE_W-1] ? CLASS_OVER : CLASS_UNDER;
   endfunction : expect_class
   task automatic chk_word(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_class(input range_class_e got, input range_class_e exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t class %b expected %b", $time, got, exp);
      end
   endtask : chk_class
   task automatic chk_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_flag
   task automatic tally_and_finish();
      $display("errors %0d of %0d compares", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   // Six captures flush the three-stage pipeline and the capture register.
   task automatic run_level(input logic signed [ANALOG_W-1:0] lvl);
      logic [CODE_W:0] e;
      logic pv;
      int got;
      got = 0;
      @(negedge clk_i);
      analog_level_i = lvl;
      pv = sample_valid_o;
      for (int k = 0; k < 200 && got < 6; k++) begin
         @(posedge clk_i);
         #1;
         // The source takes its sample one cycle after the capture end raises the clock.
         chk_flag(sample_taken_o, pv);
         pv = sample_valid_o;
         if (sample_valid_o === 1'b1) got++;
      end
      if (got < 6) begin
         num_errors++;
         tally_and_finish();
      end
      e = expect_word(int'(lvl));
      chk_word(raw_code_o, e[CODE_W-1:0]);
      chk_word(signed_code_o, e[CODE_W-1:0] ^ MSB_MASK);
      chk_class(range_class_o, expect_class(e));
      chk_word(link.code, e[CODE_W-1:0]);
      chk_flag(link.out_of_range_flag, e[CODE_W]);
   endtask : run_level
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      foreach (corners[i]) run_level(ANALOG_W'(corners[i]));
      @(negedge clk_i);
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk_word(raw_code_o, CODE_MID);
      chk_word(link.code, CODE_MID);
      chk_flag(link.out_of_range_flag, 1'b0);
      rst_i = 1'b0;
      for (int n = 0; n < 12; n++) begin
         seed = lfsr_next(seed);
         run_level(seed[15:0]);
      end
      tally_and_finish();
   end
endmodule : test_adc_output_code_and_range_flag

//--- verilog/adc_link_if.sv
// Link between the converter output pins and the capture logic.
`timescale 1ns/1ps
interface adc_link_if;
   import adc_out_pkg::*;
   logic conv_clk;
   logic [CODE_W-1:0] code;
   logic out_of_range_flag;
   modport device (input conv_clk, output code, output out_of_range_flag);
   modport host (output conv_clk, input code, input out_of_range_flag);
endinterface : adc_link_if

//--- verilog/adc_out_pkg.sv
// Constants shared by the converter output end and the capture end.
// Summary of operation
// - Results are straight binary in every range.
// - Minus reference, zero, top map to documented codes.
// - Beyond range: flag high, code clamps.
// - Flag stays low for in-range samples.
// - Flag and word share one pipeline latency.
// - Flag stays high until in-range conversion completes.
// - Capture classifies sample from flag and MSB.
// - Twos complement by inverting only the MSB.
// - Internal timing uses both conversion clock edges.
// - Clock high and low times at least 45 ns.
// - Divided conversion clock retimed by source clock.
package adc_out_pkg;
   localparam int CODE_W = 14;
   localparam int ANALOG_W = 16;
   localparam int PIPE_DEPTH = 3;
   localparam logic [CODE_W-1:0] CODE_MIN = 14'h0000;
   localparam logic [CODE_W-1:0] CODE_MID = 14'h2000;
   localparam logic [CODE_W-1:0] CODE_MAX = 14'h3FFF;
   localparam logic [CODE_W-1:0] MSB_MASK = 14'h2000;
   // Analog level is expressed in LSBs relative to zero differential input.
   localparam logic signed [ANALOG_W-1:0] LEVEL_NEG_REF = 16'hE000;
   localparam logic signed [ANALOG_W-1:0] LEVEL_POS_REF = 16'h2000;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int CLK_MIN_HALF_PS = 45000;
   // Least time rounds up to whole cycles.
   localparam int HALF_CYC = (CLK_MIN_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HALF_CNT_W = 4;
   localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(HALF_CYC - 1);
   localparam logic [HALF_CNT_W-1:0] HALF_ZERO = 4'h0;
   typedef enum logic [1:0] {
      CLASS_IN_RANGE = 2'b00,
      CLASS_UNDER = 2'b01,
      CLASS_OVER = 2'b10
   } range_class_e;
endpackage : adc_out_pkg

//--- verilog/adc_sample_capture.sv
// Capture end: makes the conversion clock and registers each sample.
`timescale 1ns/1ps
module adc_sample_capture (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Asynchronous reset, active high.
   output logic [adc_out_pkg::CODE_W-1:0] raw_code_o, // Straight binary word.
   output logic [adc_out_pkg::CODE_W-1:0] signed_code_o, // Twos complement word.
   output adc_out_pkg::range_class_e range_class_o, // In range, under or over.
   output logic sample_valid_o, // Pulse per captured sample.
   adc_link_if.host link // Converter pins.
);
   import adc_out_pkg::*;

   // ****************************************
   // Conversion clock generation
   // ****************************************
   logic [HALF_CNT_W-1:0] half_cnt_reg;
   logic [HALF_CNT_W-1:0] half_cnt_next;
   logic conv_clk_reg;
   logic conv_clk_next;
   logic capture;

   always_comb begin
      half_cnt_next = half_cnt_reg + 4'h1;
      conv_clk_next = conv_clk_reg;
      if (half_cnt_reg == HALF_LAST) begin
         half_cnt_next = HALF_ZERO;
         conv_clk_next = ~conv_clk_reg;
      end
   end
   assign capture = (half_cnt_reg == HALF_LAST) && !conv_clk_reg;

   // The divided clock leaves straight from a flop on clk_i, which retimes it.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         half_cnt_reg <= HALF_ZERO;
         conv_clk_reg <= 1'b0;
      end else begin
         half_cnt_reg <= half_cnt_next;
         conv_clk_reg <= conv_clk_next;
      end
   end

   // ****************************************
   // Sample capture
   // ****************************************
   logic [CODE_W-1:0] raw_reg;
   logic [CODE_W-1:0] raw_next;
   logic [CODE_W-1:0] signed_reg;
   logic [CODE_W-1:0] signed_next;
   range_class_e class_reg;
   range_class_e class_next;
   logic valid_reg;
   logic valid_next;

   always_comb begin
      raw_next = raw_reg;
      signed_next = signed_reg;
      class_next = class_reg;
      valid_next = capture;
      // Word and flag are taken on the same edge as the conversion clock rises.
      if (capture) begin
         raw_next = link.code;
         signed_next = link.code ^ MSB_MASK;
         if (!link.out_of_range_flag) begin
            class_next = CLASS_IN_RANGE;
         end else if ((link.code & MSB_MASK) != CODE_MIN) begin
            class_next = CLASS_OVER;
         end else begin
            class_next = CLASS_UNDER;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         raw_reg <= CODE_MID;
         signed_reg <= CODE_MIN;
         class_reg <= CLASS_IN_RANGE;
         valid_reg <= 1'b0;
      end else begin
         raw_reg <= raw_next;
         signed_reg <= signed_next;
         class_reg <= class_next;
         valid_reg <= valid_next;
      end
   end

   assign link.conv_clk = conv_clk_reg;
   assign raw_code_o = raw_reg;
   assign signed_code_o = signed_reg;
   assign range_class_o = class_reg;
   assign sample_valid_o = valid_reg;
endmodule : adc_sample_capture

//--- verilog/adc_sample_source.sv
// Converter digital output end: pipeline, code mapping and range flag.
`timescale 1ns/1ps
module adc_sample_source (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Asynchronous reset, active high.
   input wire logic signed [adc_out_pkg::ANALOG_W-1:0] analog_level_i, // Differential input in LSBs.
   output logic sample_taken_o, // Pulse when a sample enters the pipeline.
   adc_link_if.device link // Output pins.
);
   import adc_out_pkg::*;

   // ****************************************
   // Conversion and pipeline
   // ****************************************
   logic conv_prev_reg;
   logic conv_prev_next;
   logic [CODE_W-1:0] code_pipe_reg [PIPE_DEPTH];
   logic [CODE_W-1:0] code_pipe_next [PIPE_DEPTH];
   logic otr_pipe_reg [PIPE_DEPTH];
   logic otr_pipe_next [PIPE_DEPTH];
   logic [CODE_W-1:0] code_out_reg;
   logic [CODE_W-1:0] code_out_next;
   logic otr_out_reg;
   logic otr_out_next;
   logic taken_reg;
   logic taken_next;
   logic conv_rise;
   logic conv_fall;
   logic [CODE_W-1:0] conv_code;
   logic conv_otr;

   // Sampling happens on the rising edge, output update on the falling edge.
   assign conv_rise = link.conv_clk & ~conv_prev_reg;
   assign conv_fall = ~link.conv_clk & conv_prev_reg;

   always_comb begin
      conv_code = CODE_W'(analog_level_i - LEVEL_NEG_REF);
      conv_otr = 1'b0;
      if (analog_level_i < LEVEL_NEG_REF) begin
         conv_code = CODE_MIN;
         conv_otr = 1'b1;
      end else if (analog_level_i >= LEVEL_POS_REF) begin
         conv_code = CODE_MAX;
         conv_otr = 1'b1;
      end
   end

   generate
      for (genvar i = 0; i < PIPE_DEPTH; i++) begin : g_pipe
         logic [CODE_W-1:0] code_in;
         logic otr_in;
         // The head stage is split off at elaboration so no stage ever indexes below zero.
         if (i == 0) begin : g_head
            assign code_in = conv_code;
            assign otr_in = conv_otr;
         end else begin : g_tail
            assign code_in = code_pipe_reg[i-1];
            assign otr_in = otr_pipe_reg[i-1];
         end
         always_comb begin
            code_pipe_next[i] = code_pipe_reg[i];
            otr_pipe_next[i] = otr_pipe_reg[i];
            if (conv_rise) begin
               // Word and flag move in lockstep so their latency cannot differ.
               code_pipe_next[i] = code_in;
               otr_pipe_next[i] = otr_in;
            end
         end

         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               code_pipe_reg[i] <= CODE_MID;
               otr_pipe_reg[i] <= 1'b0;
            end else begin
               code_pipe_reg[i] <= code_pipe_next[i];
               otr_pipe_reg[i] <= otr_pipe_next[i];
            end
         end
      end
   endgenerate

   always_comb begin
      conv_prev_next = link.conv_clk;
      taken_next = conv_rise;
      code_out_next = code_out_reg;
      otr_out_next = otr_out_reg;
      // The flag only changes when a new conversion completes, so it holds
      // high until an in-range sample reaches the pins.
      if (conv_fall) begin
         code_out_next = code_pipe_reg[PIPE_DEPTH-1];
         otr_out_next = otr_pipe_reg[PIPE_DEPTH-1];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_prev_reg <= 1'b0;
         taken_reg <= 1'b0;
         code_out_reg <= CODE_MID;
         otr_out_reg <= 1'b0;
      end else begin
         conv_prev_reg <= conv_prev_next;
         taken_reg <= taken_next;
         code_out_reg <= code_out_next;
         otr_out_reg <= otr_out_next;
      end
   end

   assign link.code = code_out_reg;
   assign link.out_of_range_flag = otr_out_reg;
   assign sample_taken_o = taken_reg;
endmodule : adc_sample_source
